// ### pkg/pas_regs.svh
// Register offsets, field positions and reset values of the PHY management bank.
// Assumes a 5-bit register index and 16-bit register words.
`ifndef PAS_REGS_SVH
`define PAS_REGS_SVH

`define PAS_ADDR_W 5
`define PAS_DATA_W 16

`define PAS_OFF_PARTNER_BASE 5'h05
`define PAS_OFF_AN_EXPANSION 5'h06
`define PAS_OFF_LOCAL_NP 5'h07
`define PAS_OFF_PARTNER_NP 5'h08
`define PAS_OFF_RXERR_TALLY 5'h15
`define PAS_OFF_INT_CTRL 5'h1b
`define PAS_OFF_PHY_CTRL 5'h1f

`define PAS_RST_PARTNER_BASE 16'h0001
`define PAS_RST_LOCAL_NP 16'h2001
`define PAS_RST_TALLY 16'h0000
`define PAS_RST_INT_EN 8'h00
`define PAS_RST_INT_FLAG 8'h00

`define PAS_BIT_PAIRSWAP_DIS 13
`define PAS_BIT_FORCE_LINK 11
`define PAS_BIT_POWER_SAVE 10
`define PAS_BIT_INT_LEVEL 9
`define PAS_BIT_JABBER_EN 8
`define PAS_BIT_SQE_TEST 1
`define PAS_BIT_SCRAM_DIS 0
`define PAS_RST_POWER_SAVE 1'b1
`define PAS_RST_JABBER_EN 1'b1

`define PAS_BIT_NP_TOGGLE 11
`define PAS_LOCAL_NP_WMASK 16'hb7ff
`define PAS_PARTNER_BASE_MASK 16'hefff
`define PAS_INT_EN_HI 15
`define PAS_INT_EN_LO 8

`endif

// ### pkg/pas_pkg.sv
// Types shared by the PHY management register bank.
// Assumes the status struct is driven by negotiation logic on the same clock.
package pas_pkg;

  // Status reported by the negotiation and link logic
  typedef struct packed {
    logic [15:0] base_word;
    logic base_strobe;
    logic [15:0] np_word;
    logic np_strobe;
    logic pd_fault;
    logic partner_np_able;
    logic partner_an_able;
    logic tx_toggle;
    logic link_up;
    logic remote_fault;
    logic jabber;
    logic partner_ack;
    logic energy;
    logic an_done;
    logic pause_result;
    logic isolate;
    logic [2:0] op_mode;
  } pas_status_s;

  // Controls steering the PHY datapath
  typedef struct packed {
    logic mdix_auto;
    logic force_link;
    logic power_save;
    logic jabber_en;
    logic sqe_test;
    logic scram_bypass;
  } pas_ctrl_s;

  typedef enum logic [1:0] {
    PAS_RX_IDLE,
    PAS_RX_PKT,
    PAS_RX_PKT_ERR
  } pas_rx_state_e;

endpackage

// ### hw/pas_regs_top.sv
// Management register bank of a 10/100 PHY: partner ability, expansion,
// next pages, receive-error tally, interrupt control and PHY control.
// Assumes status inputs are synchronous to clk; the receive pins arrive
// from the receive clock domain and are synchronised here.
// Limitation: the receive-error tally saturates and a read never clears it.
// The interrupt pin idles high after reset, since polarity resets to active low.
`timescale 1ns/1ps
`include "pas_regs.svh"

module pas_regs_top
  import pas_pkg::*;
#(
  parameter int ADDR_W = `PAS_ADDR_W,
  parameter int DATA_W = `PAS_DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire pas_status_s phy_status,
  input wire logic rx_clk,
  input wire logic rx_dv,
  input wire logic rx_er,
  output pas_ctrl_s phy_ctrl,
  output logic [15:0] local_np_tx,
  output logic int_pin
);

  // Address match, shared by write and read decode
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [4:0] off);
    addr_hit = (a == ADDR_W'(off));
  endfunction

  // Receive pin synchronisers: stage one feeds stage two only
  logic [2:0] rx_meta;
  logic [2:0] rx_sync;
  logic rx_clk_prev;
  logic [2:0] next_rx_meta;
  logic [2:0] next_rx_sync;
  logic next_rx_clk_prev;

  always_comb begin
    next_rx_meta = {rx_clk, rx_dv, rx_er};
    next_rx_sync = rx_meta;
    next_rx_clk_prev = rx_sync[2];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_meta <= 3'h0;
      rx_sync <= 3'h0;
      rx_clk_prev <= 1'b0;
    end else begin
      rx_meta <= next_rx_meta;
      rx_sync <= next_rx_sync;
      rx_clk_prev <= next_rx_clk_prev;
    end
  end

  // Data and valid share the clock's sync delay, so sample them on its edge
  logic rx_edge;
  assign rx_edge = rx_sync[2] & ~rx_clk_prev;

  // Packet tracker: one tally step per errored packet, not per error nibble
  pas_rx_state_e rx_state;
  pas_rx_state_e next_rx_state;
  logic [15:0] tally;
  logic [15:0] next_tally;
  logic rx_err_ev;
  logic next_rx_err_ev;

  always_comb begin
    next_rx_state = rx_state;
    next_tally = tally;
    next_rx_err_ev = 1'b0;
    // Only a synchronised receive clock rise moves the tracker
    if (rx_edge) begin
      case (rx_state)
        PAS_RX_IDLE: begin
          if (rx_sync[1]) begin
            next_rx_state = rx_sync[0] ? PAS_RX_PKT_ERR : PAS_RX_PKT;
          end
        end
        PAS_RX_PKT: begin
          if (!rx_sync[1]) begin
            next_rx_state = PAS_RX_IDLE;
          end else if (rx_sync[0]) begin
            next_rx_state = PAS_RX_PKT_ERR;
          end
        end
        PAS_RX_PKT_ERR: begin
          if (!rx_sync[1]) begin
            next_rx_state = PAS_RX_IDLE;
            next_rx_err_ev = 1'b1;
            // Saturate rather than wrap so a busy line never looks clean
            if (tally != 16'hffff) begin
              next_tally = tally + 16'h0001;
            end
          end
        end
        default: begin
          next_rx_state = PAS_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state <= PAS_RX_IDLE;
      tally <= `PAS_RST_TALLY;
      rx_err_ev <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      tally <= next_tally;
      rx_err_ev <= next_rx_err_ev;
    end
  end

  // Register state
  logic [15:0] partner_base;
  logic [15:0] partner_np;
  logic pd_fault_lh;
  logic page_rx_lh;
  logic [15:0] local_np;
  logic [7:0] int_en;
  logic [7:0] int_flag;
  logic pairswap_dis;
  logic force_link;
  logic power_save;
  logic int_level;
  logic jabber_en;
  logic sqe_test;
  logic scram_dis;
  logic link_prev;

  // Next values of the register state
  logic [15:0] next_partner_base;
  logic [15:0] next_partner_np;
  logic next_pd_fault_lh;
  logic next_page_rx_lh;
  logic [15:0] next_local_np;
  logic [7:0] next_int_en;
  logic [7:0] next_int_flag;
  logic next_pairswap_dis;
  logic next_force_link;
  logic next_power_save;
  logic next_int_level;
  logic next_jabber_en;
  logic next_sqe_test;
  logic next_scram_dis;
  logic next_link_prev;

  // Next values of the registered outputs
  logic [15:0] next_rdata;
  logic next_int_pin;
  pas_ctrl_s next_ctrl;
  logic [15:0] next_np_tx;

  // Event vector, jabber at the top and link up at the bottom
  logic page_ev;
  logic [7:0] events;
  assign page_ev = phy_status.base_strobe | phy_status.np_strobe;
  assign events = {phy_status.jabber & jabber_en,
                   rx_err_ev,
                   page_ev,
                   phy_status.pd_fault,
                   phy_status.partner_ack,
                   link_prev & ~phy_status.link_up,
                   phy_status.remote_fault,
                   ~link_prev & phy_status.link_up};

  // Strobe decode per register; a read clears only its own register's flags
  logic wr_np;
  logic wr_int;
  logic wr_ctl;
  logic rd_exp;
  logic rd_int;
  assign wr_np = reg_wr & addr_hit(reg_addr, `PAS_OFF_LOCAL_NP);
  assign wr_int = reg_wr & addr_hit(reg_addr, `PAS_OFF_INT_CTRL);
  assign wr_ctl = reg_wr & addr_hit(reg_addr, `PAS_OFF_PHY_CTRL);
  assign rd_exp = reg_rd & addr_hit(reg_addr, `PAS_OFF_AN_EXPANSION);
  assign rd_int = reg_rd & addr_hit(reg_addr, `PAS_OFF_INT_CTRL);

  // Vendor control word as software reads it back
  logic [15:0] ctl_word;
  assign ctl_word = {2'b00, pairswap_dis, phy_status.energy, force_link, power_save,
                     int_level, jabber_en, phy_status.an_done, phy_status.pause_result,
                     phy_status.isolate, phy_status.op_mode, sqe_test, scram_dis};

  // Next values of the bank; a set in the read cycle beats the clear
  always_comb begin
    // Hold every register except link_prev unless a strobe below moves it
    next_partner_base = partner_base;
    next_partner_np = partner_np;
    next_local_np = local_np;
    next_int_en = int_en;
    next_pairswap_dis = pairswap_dis;
    next_force_link = force_link;
    next_power_save = power_save;
    next_int_level = int_level;
    next_jabber_en = jabber_en;
    next_sqe_test = sqe_test;
    next_scram_dis = scram_dis;
    next_link_prev = phy_status.link_up;
    // Pause, technology and selector come straight from the base word
    if (phy_status.base_strobe) begin
      next_partner_base = phy_status.base_word & `PAS_PARTNER_BASE_MASK;
    end
    // Partner next page is kept whole; software sorts out the fields
    if (phy_status.np_strobe) begin
      next_partner_np = phy_status.np_word;
    end

    // Latched and self-clearing flags; the event term keeps a set alive over the clear
    next_pd_fault_lh = (pd_fault_lh & ~rd_exp) | phy_status.pd_fault;
    next_page_rx_lh = (page_rx_lh & ~rd_exp) | page_ev;
    next_int_flag = (int_flag & {8{~rd_int}}) | events;

    // Writable words; read-only bits are masked off at the write
    if (wr_np) begin
      next_local_np = reg_wdata & `PAS_LOCAL_NP_WMASK;
    end
    // Enables sit in the upper byte; the flag byte below ignores writes
    if (wr_int) begin
      next_int_en = reg_wdata[`PAS_INT_EN_HI:`PAS_INT_EN_LO];
    end

    // Negotiation complete follows the negotiation logic; a write to it is dropped
    if (wr_ctl) begin
      next_pairswap_dis = reg_wdata[`PAS_BIT_PAIRSWAP_DIS];
      next_force_link = reg_wdata[`PAS_BIT_FORCE_LINK];
      next_power_save = reg_wdata[`PAS_BIT_POWER_SAVE];
      next_int_level = reg_wdata[`PAS_BIT_INT_LEVEL];
      next_jabber_en = reg_wdata[`PAS_BIT_JABBER_EN];
      next_sqe_test = reg_wdata[`PAS_BIT_SQE_TEST];
      next_scram_dis = reg_wdata[`PAS_BIT_SCRAM_DIS];
    end

    // Read mux; unmapped indexes read zero
    next_rdata = 16'h0000;
    if (reg_rd) begin
      case (1'b1)
        addr_hit(reg_addr, `PAS_OFF_PARTNER_BASE): next_rdata = partner_base;
        addr_hit(reg_addr, `PAS_OFF_AN_EXPANSION): begin
          next_rdata = {11'h000, pd_fault_lh, phy_status.partner_np_able, 1'b1,
                        page_rx_lh, phy_status.partner_an_able};
        end
        addr_hit(reg_addr, `PAS_OFF_LOCAL_NP): begin
          next_rdata = local_np;
          next_rdata[`PAS_BIT_NP_TOGGLE] = phy_status.tx_toggle;
        end
        addr_hit(reg_addr, `PAS_OFF_PARTNER_NP): next_rdata = partner_np;
        addr_hit(reg_addr, `PAS_OFF_RXERR_TALLY): next_rdata = tally;
        addr_hit(reg_addr, `PAS_OFF_INT_CTRL): next_rdata = {int_en, int_flag};
        addr_hit(reg_addr, `PAS_OFF_PHY_CTRL): next_rdata = ctl_word;
        default: next_rdata = 16'h0000;
      endcase
    end

    // Pin follows the flags as they stand, so it drops one cycle after a clearing read
    next_int_pin = (|(int_en & int_flag)) ~^ int_level;

    // Datapath controls are registered copies of the bank bits; mdix_auto is the inverse of pairswap_dis
    next_ctrl.mdix_auto = ~pairswap_dis;
    next_ctrl.force_link = force_link;
    next_ctrl.power_save = power_save;
    next_ctrl.jabber_en = jabber_en;
    next_ctrl.sqe_test = sqe_test;
    next_ctrl.scram_bypass = scram_dis;

    // Sent word carries the live toggle, the same one software reads back
    next_np_tx = local_np;
    next_np_tx[`PAS_BIT_NP_TOGGLE] = phy_status.tx_toggle;
  end

  // Register the bank and every output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      partner_base <= `PAS_RST_PARTNER_BASE;
      partner_np <= 16'h0000;
      pd_fault_lh <= 1'b0;
      page_rx_lh <= 1'b0;
      local_np <= `PAS_RST_LOCAL_NP;
      int_en <= `PAS_RST_INT_EN;
      int_flag <= `PAS_RST_INT_FLAG;
      pairswap_dis <= 1'b0;
      force_link <= 1'b0;
      power_save <= `PAS_RST_POWER_SAVE;
      int_level <= 1'b0;
      jabber_en <= `PAS_RST_JABBER_EN;
      sqe_test <= 1'b0;
      scram_dis <= 1'b0;
      link_prev <= 1'b0;
      // Outputs start at their idle levels
      reg_rdata <= 16'h0000;
      int_pin <= 1'b1; // Idle level of an active-low pin
      phy_ctrl <= '{mdix_auto: 1'b1, force_link: 1'b0, power_save: 1'b1,
                    jabber_en: 1'b1, sqe_test: 1'b0, scram_bypass: 1'b0};
      local_np_tx <= `PAS_RST_LOCAL_NP;
    end else begin
      partner_base <= next_partner_base;
      partner_np <= next_partner_np;
      pd_fault_lh <= next_pd_fault_lh;
      page_rx_lh <= next_page_rx_lh;
      local_np <= next_local_np;
      int_en <= next_int_en;
      int_flag <= next_int_flag;
      pairswap_dis <= next_pairswap_dis;
      force_link <= next_force_link;
      power_save <= next_power_save;
      int_level <= next_int_level;
      jabber_en <= next_jabber_en;
      sqe_test <= next_sqe_test;
      scram_dis <= next_scram_dis;
      link_prev <= next_link_prev;
      reg_rdata <= next_rdata;
      int_pin <= next_int_pin;
      phy_ctrl <= next_ctrl;
      local_np_tx <= next_np_tx;
    end
  end

endmodule

// ### bench/pas_regs_assertions.sv
// Concurrent checks on the PHY management bank ports.
// Assumes it is bound to pas_regs_top and sees its ports only.
`timescale 1ns/1ps
module pas_regs_assertions
  import pas_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire pas_status_s phy_status,
  input wire logic rx_clk,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire pas_ctrl_s phy_ctrl,
  input wire logic [15:0] local_np_tx,
  input wire logic int_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic [7:0] en_q;
  logic pol_q;

  // Shadow of enables and pin polarity, so idle level is known
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q <= 8'h00;
      pol_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 5'h1b) en_q <= reg_wdata[15:8];
      if (reg_wr && reg_addr == 5'h1f) pol_q <= reg_wdata[9];
    end
  end

  // A write, then a cycle without another write to the same place
  sequence wr_held(a);
    reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
  endsequence

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read slot");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 5'h00 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  force_link_a: assert property (wr_held(5'h1f) |=> phy_ctrl.force_link == $past(reg_wdata[11], 2))
    else $error("force link not following control");
  mdix_auto_a: assert property (wr_held(5'h1f) |=> phy_ctrl.mdix_auto == !$past(reg_wdata[13], 2))
    else $error("crossover not following pair swap disable");
  power_save_a: assert property (wr_held(5'h1f) |=> phy_ctrl.power_save == $past(reg_wdata[10], 2))
    else $error("power saving not following control");
  jabber_en_a: assert property (wr_held(5'h1f) |=> phy_ctrl.jabber_en == $past(reg_wdata[8], 2))
    else $error("jabber enable not following control");
  scram_sqe_a: assert property (wr_held(5'h1f) |=>
      {phy_ctrl.sqe_test, phy_ctrl.scram_bypass} == $past(reg_wdata[1:0], 2))
    else $error("sqe or scrambler control wrong");
  np_write_a: assert property (wr_held(5'h07) |=>
      (local_np_tx & 16'hb7ff) == ($past(reg_wdata, 2) & 16'hb7ff))
    else $error("local next page word not sent as written");
  np_toggle_a: assert property (!$past(rst) |-> local_np_tx[11] == $past(phy_status.tx_toggle))
    else $error("toggle bit not tracking last sent toggle");
  int_idle_a: assert property (en_q == 8'h00 && $past(en_q) == 8'h00 && pol_q == $past(pol_q)
      |-> int_pin == !pol_q)
    else $error("interrupt pin active with nothing enabled");
endmodule

// ### bench/pas_rx_partner.sv
// Receive-side model of the link: short frames, clock only inside send, one idle beat per frame.
// Assumes the bench calls send and waits for it to return.
`timescale 1ns/1ps
module pas_rx_partner (
  output logic rx_clk,
  output logic rx_dv,
  output logic rx_er
);
  initial begin
    rx_clk = 1'b0;
    rx_dv = 1'b0;
    rx_er = 1'b0;
  end

  // Two data beats then one idle beat; lines move on the falling edge
  task automatic send(input logic err);
    int i;
    for (i = 0; i < 3; i++) begin
      rx_dv = (i < 2);
      rx_er = err && (i == 1); // Error beat inside the packet
      #40 rx_clk = 1'b1;
      #40 rx_clk = 1'b0;
    end
    rx_er = 1'b0;
  endtask
endmodule

// ### bench/phy_autoneg_status_control_regs_tb.sv
// Self-checking bench for the PHY management register bank.
// Assumes pas_pkg is compiled first; reads are checked from a queue.
`timescale 1ns/1ps
module phy_autoneg_status_control_regs_tb;
  import pas_pkg::*;
  logic clk, rst, reg_wr, reg_rd, rd_d, int_pin, rx_clk, rx_dv, rx_er;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, local_np_tx, bw, w;
  pas_status_s st;
  pas_ctrl_s phy_ctrl;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h69d3_e55e;
  logic [4:0] ra[8] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h15, 5'h1b, 5'h1f, 5'h00};
  logic [15:0] rv[8] = '{16'h0001, 16'h0004, 16'h2001, 16'h0000, 16'h0000, 16'h0000, 16'h0500, 16'h0000};
  int miscompares = 0;
  int num_checks = 0;
  int i;

  pas_regs_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phy_status(st), .rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er),
    .phy_ctrl(phy_ctrl), .local_np_tx(local_np_tx), .int_pin(int_pin));
  pas_rx_partner rx_u (.rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is due mid-cycle after the strobe, so expectations queue
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // One event per flag position, high bit jabber down to link up
  task automatic ev(input int n);
    @(posedge clk);
    case (n)
      0: st.link_up <= 1'b1;
      1: st.remote_fault <= 1'b1;
      2: st.link_up <= 1'b0;
      3: st.partner_ack <= 1'b1;
      4: st.pd_fault <= 1'b1;
      5: st.base_strobe <= 1'b1;
      6: begin
        rx_u.send(1'b0);
        rx_u.send(1'b1);
      end
      7: st.jabber <= 1'b1;
      default: st.np_strobe <= 1'b1;
    endcase
    @(posedge clk);
    {st.remote_fault, st.partner_ack, st.pd_fault, st.base_strobe, st.jabber, st.np_strobe} <= '0;
  endtask

  // Bounded wait; the receive path lags by a few clocks
  task automatic wait_int(input logic v);
    int k;
    for (k = 0; k < 200 && int_pin !== v; k++) @(posedge clk);
    #1 check({15'h0000, int_pin}, {15'h0000, v});
  endtask

  // Read result monitor
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) check(reg_rdata, exp_q.pop_front());
  end

  initial begin
    #200000;
    miscompares++;
    wrap_up;
  end

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    st = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) rd(ra[i], rv[i]);
    w = xs();
    st.op_mode <= w[4:2];
    st.energy <= w[12];
    wr(5'h1f, w);
    rd(5'h1f, w & 16'h3f1f);
    wr(5'h1f, 16'h0700);
    w = xs();
    wr(5'h07, w);
    st.tx_toggle <= 1'b1;
    rd(5'h07, (w & 16'hb7ff) | 16'h0800);
    bw = xs();
    st.base_word <= bw;
    wr(5'h1b, 16'hff00);
    for (i = 0; i < 8; i++) begin
      ev(i);
      wait_int(1'b1);
      rd(5'h1b, 16'hff00 | (16'h0001 << i));
      wait_int(1'b0);
    end
    rd(5'h05, bw & 16'hefff);
    rd(5'h15, 16'h0001);
    rd(5'h06, 16'h0016);
    rd(5'h06, 16'h0004);
    st.partner_np_able <= 1'b1;
    st.partner_an_able <= 1'b1;
    {st.an_done, st.pause_result, st.isolate} <= 3'b111;
    st.energy <= 1'b1;
    st.op_mode <= 3'h7;
    rd(5'h06, 16'h000d);
    rd(5'h1f, 16'h17fc);
    w = xs();
    st.np_word <= w;
    ev(8);
    rd(5'h08, w);
    rd(5'h1b, 16'hff20);
    wr(5'h1f, 16'h0500);
    ev(1);
    wait_int(1'b0);
    rd(5'h1b, 16'hff02);
    wait_int(1'b1);
    repeat (4) @(posedge clk);
    wrap_up;
  end
endmodule

bind pas_regs_top pas_regs_assertions chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phy_status(phy_status), .rx_clk(rx_clk),
  .rx_dv(rx_dv), .rx_er(rx_er), .phy_ctrl(phy_ctrl), .local_np_tx(local_np_tx), .int_pin(int_pin));
